// >>> verilog/dsb_pkg.sv
/*
 Package for the dual port sequential buffer: array geometry, register
 select indices, reset values and the grouped pin structures.
 Assumes a single clock domain at 200 MHz; all pins synchronised in the top.
*/
`default_nettype none
package dsb_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int DEPTH  = 8192;
    localparam int LANE_W = 8;
    localparam int CMD_W  = 12;
    localparam int CMDRD_W = 13;

    // Register select indices on the three low address lines
    localparam logic [2:0] REG_CMD    = 3'h0;
    localparam logic [2:0] REG_START1 = 3'h1;
    localparam logic [2:0] REG_START2 = 3'h2;
    localparam logic [2:0] REG_END1   = 3'h3;
    localparam logic [2:0] REG_END2   = 3'h4;
    localparam logic [2:0] REG_FLAG   = 3'h5;

    localparam int FLAG1_BIT = 0;
    localparam int FLAG2_BIT = 1;

    localparam logic [ADDR_W-1:0] PTR_RESET   = 13'h0000;
    localparam logic [ADDR_W-1:0] START_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] END_RESET   = 13'h1FFF;
    localparam logic [CMD_W-1:0]  CMD_RESET   = 12'h000;

    // Random port control pins
    typedef struct packed {
        logic chip_sel_n;
        logic reg_sel_n;
        logic write_n;
        logic out_en_n;
        logic low_lane_n;
        logic high_lane_n;
    } dsb_rand_ctl_t;

    // Sequential port control pins
    typedef struct packed {
        logic seq_chip_select_n;
        logic advance_n;
        logic seq_write_n;
        logic pointer_load_n;
        logic begin_jump1_n;
        logic begin_jump2_n;
        logic seq_out_drive_n;
    } dsb_seq_ctl_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_READ  = 2'b01,
        SEQ_WRITE = 2'b11
    } dsb_seq_state_t;
endpackage
`default_nettype wire

// >>> verilog/dsb_sync.sv
/*
 Two flip-flop synchroniser for a bus of asynchronous pin levels.
 Assumes the destination clock clk and asynchronous active-low reset.
*/
`default_nettype none
module dsb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/dsb_ram.sv
/*
 Shared 8192 x 16 storage with a byte-lane write port A, a whole-word write port B and two read ports.
 Assumes both ports on clk; a same-word collision resolves in port B's favour.
*/
`default_nettype none
module dsb_ram (
    // Clock
    input  wire logic                        clk,
    // Port A
    input  wire logic [dsb_pkg::ADDR_W-1:0]  a_addr,
    input  wire logic [1:0]                  a_we,
    input  wire logic [dsb_pkg::DATA_W-1:0]  a_wdata,
    output logic      [dsb_pkg::DATA_W-1:0]  a_rdata,
    // Port B
    input  wire logic [dsb_pkg::ADDR_W-1:0]  b_addr,
    input  wire logic                        b_we,
    input  wire logic [dsb_pkg::DATA_W-1:0]  b_wdata,
    output logic      [dsb_pkg::DATA_W-1:0]  b_rdata
);
    logic [dsb_pkg::DATA_W-1:0] mem [dsb_pkg::DEPTH];

    always_ff @(posedge clk) begin
        if (a_we[0]) begin
            mem[a_addr][dsb_pkg::LANE_W-1:0] <= a_wdata[dsb_pkg::LANE_W-1:0];
        end
        if (a_we[1]) begin
            mem[a_addr][dsb_pkg::DATA_W-1:dsb_pkg::LANE_W] <=
                a_wdata[dsb_pkg::DATA_W-1:dsb_pkg::LANE_W];
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// >>> verilog/dsb_top.sv
/*
 Dual port sequential buffer memory: a random-access port with byte lanes
 and a register select, and a sequential port with an auto-advancing
 pointer, two start addresses and two end-of-buffer flags.
 Assumes all pins are asynchronous to clk and sampled through two flops;
 the sequential clock edge is seen as a one-cycle enable pulse. Pin output
 enables are low while the design drives the pin.
*/
`default_nettype none
module dsb_top (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Random port
    input  wire logic [dsb_pkg::ADDR_W-1:0]  rand_addr,
    input  wire dsb_pkg::dsb_rand_ctl_t      rand_ctl,
    input  wire logic [dsb_pkg::DATA_W-1:0]  rand_data_in,
    output logic      [dsb_pkg::DATA_W-1:0]  rand_data_out,
    output logic      [1:0]                  rand_data_oe_n,
    // Sequential port
    input  wire logic                        seq_clk,
    input  wire dsb_pkg::dsb_seq_ctl_t       seq_ctl,
    input  wire logic [dsb_pkg::DATA_W-1:0]  seq_data_in,
    output logic      [dsb_pkg::DATA_W-1:0]  seq_data_out,
    output logic                             seq_data_oe_n,
    // Flags
    output logic                             end_flag1_n,
    output logic                             end_flag2_n
);
    localparam int RW = dsb_pkg::ADDR_W + 6 + dsb_pkg::DATA_W;
    localparam int SW = 1 + 7 + dsb_pkg::DATA_W;

    // Synchronised pins
    logic [RW-1:0]               r_sync;
    logic [SW-1:0]               s_sync;
    logic [dsb_pkg::ADDR_W-1:0]  ra;
    dsb_pkg::dsb_rand_ctl_t      rc;
    logic [dsb_pkg::DATA_W-1:0]  rd;
    logic                        sclk_s;
    dsb_pkg::dsb_seq_ctl_t       sc;
    logic [dsb_pkg::DATA_W-1:0]  sd;

    dsb_sync #(.W(RW), .INIT({{dsb_pkg::ADDR_W{1'b0}}, 6'h3F, {dsb_pkg::DATA_W{1'b0}}})) u_rsync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({rand_addr, rand_ctl, rand_data_in}),
        .q     (r_sync)
    );
    dsb_sync #(.W(SW), .INIT({1'b0, 7'h7F, {dsb_pkg::DATA_W{1'b0}}})) u_ssync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({seq_clk, seq_ctl, seq_data_in}),
        .q     (s_sync)
    );

    assign {ra, rc, rd}     = r_sync;
    assign {sclk_s, sc, sd} = s_sync;

    // Sequential clock edge as enable pulse
    logic sclk_d;
    wire  seq_edge = sclk_s & ~sclk_d;

    // Pointer state
    logic [dsb_pkg::ADDR_W-1:0]  ptr;
    logic [dsb_pkg::ADDR_W-1:0]  load_hold;
    logic                        load_pend;
    logic [dsb_pkg::ADDR_W-1:0]  start1;
    logic [dsb_pkg::ADDR_W-1:0]  start2;
    logic [dsb_pkg::ADDR_W-1:0]  end1;
    logic [dsb_pkg::ADDR_W-1:0]  end2;
    logic [dsb_pkg::CMD_W-1:0]   cmd_reg;
    logic                        seq_enabled;
    dsb_pkg::dsb_seq_state_t     seq_state;
    dsb_pkg::dsb_seq_state_t     next_seq_state;

    // Random port decode
    wire rand_sel  = ~rc.chip_sel_n & rc.reg_sel_n;
    wire reg_sel   = ~rc.reg_sel_n & rc.chip_sel_n;
    wire any_sel   = rand_sel | reg_sel;
    wire rd_cycle  = any_sel & rc.write_n & ~rc.out_en_n;
    wire [1:0] lane_on = {~rc.high_lane_n, ~rc.low_lane_n};
    wire [1:0] arr_we  = (rand_sel & ~rc.write_n) ? lane_on : 2'b00;
    wire reg_wr_strobe = reg_sel & ~rc.write_n;
    wire [2:0] reg_idx = ra[2:0];

    logic reg_wr_d;
    wire  reg_wr = reg_wr_strobe & ~reg_wr_d;

    // Lane merge for register writes
    function automatic logic [dsb_pkg::ADDR_W-1:0] lane_merge(
        input logic [dsb_pkg::ADDR_W-1:0] old_v,
        input logic [dsb_pkg::DATA_W-1:0] new_v,
        input logic [1:0]                 lanes
    );
        logic [dsb_pkg::DATA_W-1:0] r;
        r = {3'h0, old_v};
        if (lanes[0]) begin
            r[dsb_pkg::LANE_W-1:0] = new_v[dsb_pkg::LANE_W-1:0];
        end
        if (lanes[1]) begin
            r[dsb_pkg::DATA_W-1:dsb_pkg::LANE_W] = new_v[dsb_pkg::DATA_W-1:dsb_pkg::LANE_W];
        end
        return r[dsb_pkg::ADDR_W-1:0];
    endfunction

    wire wr_cmd    = reg_wr & (reg_idx == dsb_pkg::REG_CMD);
    wire wr_start1 = reg_wr & (reg_idx == dsb_pkg::REG_START1);
    wire wr_start2 = reg_wr & (reg_idx == dsb_pkg::REG_START2);
    wire wr_end1   = reg_wr & (reg_idx == dsb_pkg::REG_END1);
    wire wr_end2   = reg_wr & (reg_idx == dsb_pkg::REG_END2);
    wire wr_flag   = reg_wr & (reg_idx == dsb_pkg::REG_FLAG);
    wire [dsb_pkg::ADDR_W-1:0] cmd_merged =
        lane_merge({1'b0, cmd_reg}, rd, lane_on);

    // Sequential decode
    wire do_load   = seq_edge & ~sc.pointer_load_n;
    wire do_jump1  = seq_edge & ~sc.begin_jump1_n & ~load_pend;
    wire do_jump2  = seq_edge & ~sc.begin_jump2_n & ~load_pend & sc.begin_jump1_n;
    wire do_adv    = seq_edge & ~sc.advance_n;
    wire [dsb_pkg::ADDR_W-1:0] ptr_inc = ptr + 13'h0001;
    wire seq_wr_now = seq_edge & ~sc.seq_chip_select_n & ~sc.seq_write_n;
    wire hit1 = do_adv & ~load_pend & ~do_jump1 & ~do_jump2 & (ptr_inc == end1);
    wire hit2 = do_adv & ~load_pend & ~do_jump1 & ~do_jump2 & (ptr_inc == end2);

    // Register read mux
    logic [dsb_pkg::DATA_W-1:0] reg_rdata;
    always_comb begin
        case (reg_idx)
            dsb_pkg::REG_CMD:    reg_rdata = {3'h0, 1'b0, cmd_reg};
            dsb_pkg::REG_START1: reg_rdata = {3'h0, start1};
            dsb_pkg::REG_START2: reg_rdata = {3'h0, start2};
            dsb_pkg::REG_END1:   reg_rdata = {3'h0, end1};
            dsb_pkg::REG_END2:   reg_rdata = {3'h0, end2};
            dsb_pkg::REG_FLAG:   reg_rdata = {14'h0000, ~end_flag2_n, ~end_flag1_n};
            default:             reg_rdata = 16'h0000;
        endcase
    end

    // Shared array
    logic [dsb_pkg::DATA_W-1:0] arr_rdata;
    logic [dsb_pkg::DATA_W-1:0] seq_rdata;
    dsb_ram u_ram (
        .clk     (clk),
        .a_addr  (ra),
        .a_we    (arr_we),
        .a_wdata (rd),
        .a_rdata (arr_rdata),
        .b_addr  (ptr),
        .b_we    (seq_wr_now),
        .b_wdata (sd),
        .b_rdata (seq_rdata)
    );

    // Sequential access state
    always_comb begin
        case (seq_state)
            dsb_pkg::SEQ_IDLE,
            dsb_pkg::SEQ_READ,
            dsb_pkg::SEQ_WRITE: begin
                if (!seq_edge) begin
                    next_seq_state = seq_state;
                end else if (sc.seq_chip_select_n) begin
                    next_seq_state = dsb_pkg::SEQ_IDLE;
                end else if (!sc.seq_write_n) begin
                    next_seq_state = dsb_pkg::SEQ_WRITE;
                end else if (!sc.seq_out_drive_n) begin
                    next_seq_state = dsb_pkg::SEQ_READ;
                end else begin
                    next_seq_state = dsb_pkg::SEQ_IDLE;
                end
            end
            default: next_seq_state = dsb_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d      <= 1'b0;
            reg_wr_d    <= 1'b0;
            seq_state   <= dsb_pkg::SEQ_IDLE;
            seq_enabled <= 1'b0;
        end else begin
            sclk_d      <= sclk_s;
            reg_wr_d    <= reg_wr_strobe;
            seq_state   <= next_seq_state;
            if (seq_edge) begin
                seq_enabled <= ~sc.seq_chip_select_n;
            end
        end
    end

    // Pointer and load holding register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr       <= dsb_pkg::PTR_RESET;
            load_hold <= dsb_pkg::PTR_RESET;
            load_pend <= 1'b0;
        end else begin
            if (do_load) begin
                load_hold <= sd[dsb_pkg::ADDR_W-1:0];
            end
            if (seq_edge) begin
                load_pend <= do_load;
            end
            if (seq_edge & load_pend) begin
                ptr <= load_hold;
            end else if (do_jump1) begin
                ptr <= start1;
            end else if (do_jump2) begin
                ptr <= start2;
            end else if (do_adv) begin
                ptr <= ptr_inc;
            end
        end
    end

    // Pointer control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= dsb_pkg::CMD_RESET;
            start1  <= dsb_pkg::START_RESET;
            start2  <= dsb_pkg::START_RESET;
            end1    <= dsb_pkg::END_RESET;
            end2    <= dsb_pkg::END_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= cmd_merged[dsb_pkg::CMD_W-1:0];
            end
            if (wr_start1) begin
                start1 <= lane_merge(start1, rd, lane_on);
            end
            if (wr_start2) begin
                start2 <= lane_merge(start2, rd, lane_on);
            end
            if (wr_end1) begin
                end1 <= lane_merge(end1, rd, lane_on);
            end
            if (wr_end2) begin
                end2 <= lane_merge(end2, rd, lane_on);
            end
        end
    end

    // End-of-buffer flags: a match wins over a software clear
    wire clr1 = wr_flag & lane_on[0] & ~rd[dsb_pkg::FLAG1_BIT];
    wire clr2 = wr_flag & lane_on[0] & ~rd[dsb_pkg::FLAG2_BIT];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            end_flag1_n <= 1'b1;
            end_flag2_n <= 1'b1;
        end else begin
            if (hit1) begin
                end_flag1_n <= 1'b0;
            end else if (clr1) begin
                end_flag1_n <= 1'b1;
            end
            if (hit2) begin
                end_flag2_n <= 1'b0;
            end else if (clr2) begin
                end_flag2_n <= 1'b1;
            end
        end
    end

    // Pin drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rand_data_out  <= 16'h0000;
            rand_data_oe_n <= 2'b11;
            seq_data_out   <= 16'h0000;
            seq_data_oe_n  <= 1'b1;
        end else begin
            rand_data_out  <= rand_sel ? arr_rdata : reg_rdata;
            rand_data_oe_n <= rd_cycle ? ~lane_on : 2'b11;
            seq_data_out   <= seq_rdata;
            seq_data_oe_n  <= ~(seq_enabled & ~sc.seq_out_drive_n);
        end
    end
endmodule
`default_nettype wire

// >>> dv/dsb_chk.sv
/*
 Pin-level checks on dsb_top, bound into every instance.
 Assumes pins change away from the rising clk edge; rst_n async, active low.
*/
`default_nettype none
module dsb_chk (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rst_n,
    // Random port
    input wire dsb_pkg::dsb_rand_ctl_t        rand_ctl,
    input wire logic [1:0]                    rand_data_oe_n,
    // Sequential port
    input wire logic                          seq_clk,
    input wire dsb_pkg::dsb_seq_ctl_t         seq_ctl,
    input wire logic [dsb_pkg::DATA_W-1:0]    seq_data_out,
    input wire logic                          seq_data_oe_n,
    // Flags
    input wire logic                          end_flag1_n,
    input wire logic                          end_flag2_n
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic       seq_q;
    logic [6:0] ctl_q;
    logic [7:0] since_rise;
    logic [7:0] since_reg_wr;
    logic [7:0] quiet;
    wire        rise_w = seq_clk & ~seq_q;
    wire        reg_wr_w = rand_ctl.chip_sel_n & ~rand_ctl.reg_sel_n & ~rand_ctl.write_n;
    wire        arr_wr_w = ~rand_ctl.chip_sel_n & rand_ctl.reg_sel_n & ~rand_ctl.write_n;
    wire        busy_w = rise_w | arr_wr_w | (seq_ctl != ctl_q);
    wire [7:0]  next_since_rise = rise_w ? 8'h00 : since_rise + {7'h00, since_rise != 8'hFF};
    wire [7:0]  next_since_reg_wr = reg_wr_w ? 8'h00 :
                                    since_reg_wr + {7'h00, since_reg_wr != 8'hFF};
    wire [7:0]  next_quiet = busy_w ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};

    // Cycle counters since the last cause of each kind of output change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= 1'b0;
            ctl_q <= 7'h00;
            since_rise <= 8'h00;
            since_reg_wr <= 8'h00;
            quiet <= 8'h00;
        end else begin
            seq_q <= seq_clk;
            ctl_q <= seq_ctl;
            since_rise <= next_since_rise;
            since_reg_wr <= next_since_reg_wr;
            quiet <= next_quiet;
        end
    end

    sequence s_rand_off;
        (rand_ctl.chip_sel_n && rand_ctl.reg_sel_n) [*6];
    endsequence
    sequence s_both_sel;
        (!rand_ctl.chip_sel_n && !rand_ctl.reg_sel_n) [*6];
    endsequence

    property p_deselect_float;
        s_rand_off |-> rand_data_oe_n == 2'b11;
    endproperty
    property p_both_sel_float;
        s_both_sel |-> rand_data_oe_n == 2'b11;
    endproperty
    property p_no_read_float;
        (rand_ctl.out_en_n || !rand_ctl.write_n) [*6] |-> rand_data_oe_n == 2'b11;
    endproperty
    property p_low_lane_off;
        rand_ctl.low_lane_n [*6] |-> rand_data_oe_n[0];
    endproperty
    property p_high_lane_off;
        rand_ctl.high_lane_n [*6] |-> rand_data_oe_n[1];
    endproperty
    property p_seq_drive_off;
        seq_ctl.seq_out_drive_n [*6] |-> seq_data_oe_n;
    endproperty
    property p_flag_fall;
        ($fell(end_flag1_n) || $fell(end_flag2_n)) |-> since_rise <= 8'd8;
    endproperty
    property p_flag_clear;
        ($rose(end_flag1_n) || $rose(end_flag2_n)) |-> since_reg_wr <= 8'd10;
    endproperty
    property p_seq_deselect;
        ($rose(seq_data_oe_n) && !seq_ctl.seq_out_drive_n) |-> since_rise <= 8'd8;
    endproperty
    property p_seq_hold;
        quiet > 8'd12 |-> $stable(seq_data_out);
    endproperty

    a_deselect_float: assert property (p_deselect_float) else $error("random bus driven");
    a_both_sel_float: assert property (p_both_sel_float) else $error("double select");
    a_no_read_float: assert property (p_no_read_float) else $error("bus driven, no read");
    a_low_lane_off: assert property (p_low_lane_off) else $error("low lane driven");
    a_high_lane_off: assert property (p_high_lane_off) else $error("high lane driven");
    a_seq_drive_off: assert property (p_seq_drive_off) else $error("seq bus driven");
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell, no edge");
    a_flag_clear: assert property (p_flag_clear) else $error("flag rose, no write");
    a_seq_deselect: assert property (p_seq_deselect) else $error("seq off, no edge");
    a_seq_hold: assert property (p_seq_hold) else $error("seq data moved");
endmodule

bind dsb_top dsb_chk i_chk (
    .clk            (clk),
    .rst_n          (rst_n),
    .rand_ctl       (rand_ctl),
    .rand_data_oe_n (rand_data_oe_n),
    .seq_clk        (seq_clk),
    .seq_ctl        (seq_ctl),
    .seq_data_out   (seq_data_out),
    .seq_data_oe_n  (seq_data_oe_n),
    .end_flag1_n    (end_flag1_n),
    .end_flag2_n    (end_flag2_n)
);
`default_nettype wire

// >>> dv/dsb_seq_src.sv
/*
 Streaming-side model: makes one sequential clock period per request.
 Assumes go is raised after a falling clk edge and held until busy rises.
*/
`default_nettype none
module dsb_seq_src (
    // Clock
    input  wire logic clk,
    // Request
    input  wire logic go,
    // Sequential clock
    output logic      seq_clk,
    output logic      busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands low between requests; each phase lasts six clk
    initial begin
        seq_clk = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (6) @(posedge clk);
                seq_clk <= 1'b1;
                repeat (6) @(posedge clk);
                seq_clk <= 1'b0;
                repeat (6) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/dual_port_sequential_buffer_ram_test.sv
/*
 Self-checking bench for dsb_top: random port, registers, sequential pointer.
 Assumes dsb_pkg, dsb_top, dsb_seq_src and the bound checker are compiled.
*/
`default_nettype none
module dual_port_sequential_buffer_ram_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [36:0] v;
        logic [36:0] m;
    } dsb_exp_t;
    logic                   clk, rst_n, seq_clk, go, busy;
    logic [12:0]            rand_addr;
    dsb_pkg::dsb_rand_ctl_t rand_ctl;
    dsb_pkg::dsb_seq_ctl_t  seq_ctl;
    logic [15:0]            rand_data_in, seq_data_in, rand_data_out, seq_data_out;
    logic [1:0]             rand_data_oe_n;
    logic                   seq_data_oe_n, end_flag1_n, end_flag2_n;
    wire  [36:0]            obs = {end_flag2_n, end_flag1_n, seq_data_oe_n,
                                   rand_data_oe_n, seq_data_out, rand_data_out};
    dsb_exp_t               exp_q[$];
    dsb_exp_t               e;
    event                   look;
    int                     n_fail, num_checks;
    logic [31:0]            xs = 32'h00000004;

    dsb_top i_dut (
        .clk(clk), .rst_n(rst_n), .rand_addr(rand_addr), .rand_ctl(rand_ctl),
        .rand_data_in(rand_data_in), .rand_data_out(rand_data_out),
        .rand_data_oe_n(rand_data_oe_n), .seq_clk(seq_clk), .seq_ctl(seq_ctl),
        .seq_data_in(seq_data_in), .seq_data_out(seq_data_out),
        .seq_data_oe_n(seq_data_oe_n), .end_flag1_n(end_flag1_n), .end_flag2_n(end_flag2_n)
    );
    dsb_seq_src i_src (.clk(clk), .go(go), .seq_clk(seq_clk), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function logic [31:0] nxt();
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction

    task wrap_up;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [36:0] v, input logic [36:0] m);
        exp_q.push_back('{v, m});
        ->look;
    endtask

    task chk_r(input logic [1:0] oe, input logic [15:0] d);
        chk({5'b00000 | oe, 16'h0000, d & {{8{~oe[1]}}, {8{~oe[0]}}}},
            {5'b00011, 16'h0000, {8{~oe[1]}}, {8{~oe[0]}}});
    endtask

    task chk_s(input logic [1:0] fl, input logic [15:0] d);
        chk({fl, 3'b000, d, 16'h0000}, {5'b11100, 16'hFFFF, 16'h0000});
    endtask

    // One random-port access, held well past the answer latency
    task rnd(input logic [5:0] c, input logic [12:0] a, input logic [15:0] d,
             input logic [1:0] oe, input logic [15:0] x);
        rand_ctl = c;
        rand_addr = a;
        rand_data_in = d;
        repeat (7) @(negedge clk);
        chk_r(oe, x);
        @(negedge clk) rand_ctl = 6'h3F;
        repeat (3) @(negedge clk);
    endtask

    task wt(input logic v);
        for (int i = 0; i < 40 && busy !== v; i++) @(negedge clk);
        if (busy !== v) begin
            n_fail++;
            $display("wrong value at %0t: handshake timeout", $time);
            wrap_up();
        end
    endtask

    task sq(input logic [6:0] c, input logic [15:0] d);
        seq_ctl = c;
        seq_data_in = d;
        go = 1'b1;
        wt(1'b1);
        go = 1'b0;
        wt(1'b0);
    endtask

    // Scoreboard: oldest expectation against the settled outputs
    initial forever begin
        @(look);
        #1;
        e = exp_q.pop_front();
        num_checks++;
        if ((obs & e.m) !== e.v) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h mask %h", $time, obs, e.v, e.m);
        end
    end

    initial begin
        logic [31:0] r;
        rst_n = 1'b0;
        go = 1'b0;
        rand_addr = 13'h0000;
        rand_ctl = 6'h3F;
        rand_data_in = 16'h0000;
        seq_ctl = 7'h7F;
        seq_data_in = 16'h0000;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({5'b11111, 32'h00000000}, {5'b11111, 32'h00000000});
        for (int a = 0; a < 8; a++) rnd(6'b010100, 13'(a), 16'h1000 + 16'(a), 2'b11, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            r = nxt();
            rnd(6'b010100, {5'h01, r[7:0]}, r[31:16], 2'b11, 16'h0000);
            rnd(6'b011000, {5'h01, r[7:0]}, 16'h0000, 2'b00, r[31:16]);
        end
        rnd(6'b010100, 13'h0008, 16'hA5C3, 2'b11, 16'h0000);
        rnd(6'b010101, 13'h0008, 16'h0F3C, 2'b11, 16'h0000);
        rnd(6'b011000, 13'h0008, 16'h0000, 2'b00, 16'hA53C);
        rnd(6'b011010, 13'h0008, 16'h0000, 2'b01, 16'hA500);
        rnd(6'b011100, 13'h0008, 16'h0000, 2'b11, 16'h0000);
        rnd(6'b111111, 13'h0008, 16'h0000, 2'b11, 16'h0000);
        rnd(6'b001000, 13'h0008, 16'h0000, 2'b11, 16'h0000);
        rnd(6'b100100, 13'(dsb_pkg::REG_END1), 16'h0003, 2'b11, 16'h0000);
        rnd(6'b100100, 13'(dsb_pkg::REG_END2), 16'h0006, 2'b11, 16'h0000);
        rnd(6'b100100, 13'(dsb_pkg::REG_START1), 16'h0005, 2'b11, 16'h0000);
        rnd(6'b100100, 13'(dsb_pkg::REG_START2), 16'h0002, 2'b11, 16'h0000);
        rnd(6'b100100, 13'(dsb_pkg::REG_CMD), 16'hFFFF, 2'b11, 16'h0000);
        rnd(6'b101000, 13'(dsb_pkg::REG_CMD), 16'h0000, 2'b00, 16'h0FFF);
        rnd(6'b101000, 13'(dsb_pkg::REG_END1), 16'h0000, 2'b00, 16'h0003);
        rnd(6'b101000, 13'h0007, 16'h0000, 2'b00, 16'h0000);
        sq(7'b0111110, 16'h0000);
        chk_s(2'b11, 16'h1000);
        for (int k = 1; k < 4; k++) begin
            sq(7'b0011110, 16'h0000);
            chk_s((k == 3) ? 2'b10 : 2'b11, 16'h1000 + 16'(k));
        end
        rnd(6'b101000, 13'(dsb_pkg::REG_FLAG), 16'h0000, 2'b00, 16'h0001);
        rnd(6'b100100, 13'(dsb_pkg::REG_FLAG), 16'h0000, 2'b11, 16'h0000);
        for (int k = 4; k < 7; k++) begin
            sq(7'b0011110, 16'h0000);
            chk_s((k == 6) ? 2'b01 : 2'b11, 16'h1000 + 16'(k));
        end
        rnd(6'b100100, 13'(dsb_pkg::REG_FLAG), 16'h0000, 2'b11, 16'h0000);
        sq(7'b0110110, 16'hE001);
        chk_s(2'b11, 16'h1006);
        sq(7'b0111110, 16'h0000);
        chk_s(2'b11, 16'h1001);
        sq(7'b0111010, 16'h0000);
        chk_s(2'b11, 16'h1005);
        sq(7'b0111100, 16'h0000);
        chk_s(2'b11, 16'h1002);
        sq(7'b0101111, 16'hBEEF);
        rnd(6'b011000, 13'h0002, 16'h0000, 2'b00, 16'hBEEF);
        sq(7'b0011110, 16'h0000);
        chk_s(2'b10, 16'h1003);
        sq(7'b1011110, 16'h0000);
        chk({5'b10100, 32'h00000000}, {5'b11100, 32'h00000000});
        sq(7'b0111110, 16'h0000);
        chk_s(2'b10, 16'h1004);
        seq_ctl = 7'b0111111;
        repeat (8) @(negedge clk);
        chk({5'b00100, 32'h00000000}, {5'b00100, 32'h00000000});
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({5'b11111, 32'h00000000}, {5'b11111, 32'h00000000});
        sq(7'b0111110, 16'h0000);
        chk_s(2'b11, 16'h1000);
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
